// ---- common/mswc_defines.svh ----
// Constants shared by both ends of the multi-sector write taskfile link.
`ifndef MSWC_DEFINES_SVH
`define MSWC_DEFINES_SVH
// ==================================================================
// Taskfile register addresses
`define MSWC_TF_DATA 3'h0
`define MSWC_TF_ERR 3'h1
`define MSWC_TF_CNT 3'h2
`define MSWC_TF_SNUM 3'h3
`define MSWC_TF_CLO 3'h4
`define MSWC_TF_CHI 3'h5
`define MSWC_TF_DH 3'h6
`define MSWC_TF_CMD 3'h7
// ==================================================================
// Opcodes
`define MSWC_OP_WRMULT 8'hC5
`define MSWC_OP_LOGDMA 8'h57
// ==================================================================
// Status and error bit positions, error masks
`define MSWC_ST_ERR 0
`define MSWC_ER_UNC 6
`define MSWC_ER_IDN 4
`define MSWC_ER_ABT 2
`define MSWC_ERMASK_LOG 8'hD4
`define MSWC_ERMASK_MULT 8'h14
// ==================================================================
// Drive/head layout, reset value and geometry
`define MSWC_DH_LBA 6
`define MSWC_DH_RST 8'hA0
`define MSWC_LAST_WORD 8'hFF
`define MSWC_ZERO_COUNT 9'h100
`define MSWC_SPT 8'h3F
`define MSWC_HEAD_LAST 4'hF
// ==================================================================
// Controller register byte offsets and interrupt bits
`define MSWC_A_CNT 6'h00
`define MSWC_A_SNUM 6'h04
`define MSWC_A_CLO 6'h08
`define MSWC_A_CHI 6'h0C
`define MSWC_A_DH 6'h10
`define MSWC_A_CMD 6'h14
`define MSWC_A_DATA 6'h18
`define MSWC_A_RESA 6'h1C
`define MSWC_A_RESB 6'h20
`define MSWC_A_IST 6'h24
`define MSWC_A_IMASK 6'h28
`define MSWC_A_ENG 6'h2C
`define MSWC_INT_DONE 0
`define MSWC_INT_ERR 1
`endif

// ---- common/mswc_pkg.sv ----
// Types for the multi-sector write device and controller.
package mswc_pkg;
   // ==================================================================
   // Device state
   typedef enum logic [1:0] {MSWC_D_IDLE, MSWC_D_XFER, MSWC_D_BUSY} mswc_dstate_type;
   typedef struct packed {
      mswc_dstate_type state;
      logic [7:0]      cnt;
      logic [7:0]      snum;
      logic [7:0]      clo;
      logic [7:0]      chi;
      logic [7:0]      dh;
      logic [7:0]      err;
      logic            errflag;
      logic            is_log;
      logic [8:0]      rem;
      logic [7:0]      words;
      logic [7:0]      blk;
      logic            first_done;
      logic            irq;
      logic [15:0]     rdata;
      logic [15:0]     mdata;
      logic            mvalid;
      logic            sdone;
   } mswc_dev_type;
   // ==================================================================
   // Controller state
   typedef enum logic [2:0] {MSWC_H_IDLE, MSWC_H_SEND, MSWC_H_FETCH, MSWC_H_WAIT,
                             MSWC_H_CATCH} mswc_hstate_type;
   typedef struct packed {
      mswc_hstate_type state;
      logic [2:0]      step;
      logic [7:0]      cnt;
      logic [7:0]      snum;
      logic [7:0]      clo;
      logic [7:0]      chi;
      logic [7:0]      dh;
      logic [7:0]      cmd;
      logic [31:0]     res_a;
      logic [23:0]     res_b;
      logic [1:0]      ist;
      logic [1:0]      imask;
      logic            rd_ack;
      logic [31:0]     rdata;
      logic            tf_wr;
      logic            tf_rd;
      logic [2:0]      tf_addr;
      logic [15:0]     tf_wdata;
   } mswc_host_type;
endpackage

// ---- common/mswc_if.sv ----
// Taskfile link between the controller and the device.
interface mswc_if;
   logic [2:0]  tf_addr;
   logic        tf_wr;
   logic        tf_rd;
   logic [15:0] tf_wdata;
   logic [15:0] tf_rdata;
   logic        intrq;
   modport dev  (input tf_addr, tf_wr, tf_rd, tf_wdata, output tf_rdata, intrq);
   modport host (output tf_addr, tf_wr, tf_rd, tf_wdata, input tf_rdata, intrq);
endinterface

// ---- core/mswc_device.sv ----
// Device end: taskfile registers, multi-sector write and DMA log write engine.
// Notes on behaviour
// - Opcode C5h starts the multi-sector write.
// - One interrupt per configured block of sectors.
// - Payload moves as 16-bit data register words.
// - Sector count zero means 256 sectors.
// - LBA mode: sector number holds bits 0-7.
// - LBA mode: cylinder registers hold bits 8-23.
// - LBA mode: head field holds bits 24-27.
// - CHS mode: sector, cylinder, head give start.
// - Count register ends as sectors not transferred.
// - CHS completion reports last sector and cylinder.
// - LBA completion reports last transferred address.
// - Opcode 57h is the DMA log write.
// - DMA log write never sets track/mark bits.
// - Abort log write: oversize, read-only, unsupported.
//
// Chosen here: register access over Avalon-MM and the placing of the registers.
`include "mswc_defines.svh"
module mswc_device (
   input  wire logic        REF_CLK,
   input  wire logic        SYS_RST,
   mswc_if.dev              TF,
   input  wire logic [7:0]  BLOCK_SECTORS,
   input  wire logic [7:0]  LOG_SECTORS,
   input  wire logic        LOG_READ_ONLY,
   input  wire logic        LOG_SUPPORTED,
   input  wire logic        MEDIA_ERROR,
   output logic      [15:0] MEDIA_WORD,
   output logic             MEDIA_VALID,
   output logic             SECTOR_DONE
);
   mswc_pkg::mswc_dev_type s_reg;
   mswc_pkg::mswc_dev_type s_next;
   logic [8:0]  req_count;
   logic [8:0]  rem_dec;
   logic [7:0]  status;
   logic [7:0]  err_out;
   logic        device_occupied;
   logic        transfer_request;
   logic [27:0] next_addr;
   logic        log_bad;

   // ==================================================================
   // Address stepping
   // The address word is {head, cylinder high, cylinder low, sector number}.
   function automatic logic [27:0] mswc_step_addr(input logic lba, input logic [27:0] a);
      logic [27:0] r;
      r = a;
      if (lba) begin
         r = a + 28'h0000001;
      end else if (a[7:0] != `MSWC_SPT) begin
         r[7:0] = a[7:0] + 8'h01;
      end else begin
         r[7:0] = 8'h01;
         if (a[27:24] != `MSWC_HEAD_LAST) begin
            r[27:24] = a[27:24] + 4'h1;
         end else begin
            r[27:24] = 4'h0;
            r[23:8] = a[23:8] + 16'h0001;
         end
      end
      return r;
   endfunction

   // ==================================================================
   // Status and error views
   assign device_occupied = (s_reg.state == mswc_pkg::MSWC_D_BUSY);
   assign transfer_request = (s_reg.state == mswc_pkg::MSWC_D_XFER);
   assign status = {device_occupied, 1'b1, 1'b0, 1'b1, transfer_request, 1'b0, 1'b0, s_reg.errflag};
   // Masking at the output keeps illegal bits at zero whatever path set them.
   assign err_out = s_reg.err & (s_reg.is_log ? `MSWC_ERMASK_LOG : `MSWC_ERMASK_MULT);
   assign req_count = (s_reg.cnt == 8'h00) ? `MSWC_ZERO_COUNT : {1'b0, s_reg.cnt};
   assign rem_dec = s_reg.rem - 9'h001;
   assign next_addr = mswc_step_addr(s_reg.dh[`MSWC_DH_LBA],
                                     {s_reg.dh[3:0], s_reg.chi, s_reg.clo, s_reg.snum});
   assign log_bad = !LOG_SUPPORTED || LOG_READ_ONLY || (s_reg.cnt == 8'h00) ||
                    (s_reg.cnt > LOG_SECTORS);

   // ==================================================================
   // Next state
   always_comb begin
      s_next = s_reg;
      s_next.mvalid = 1'b0;
      s_next.sdone = 1'b0;
      if (TF.tf_rd) begin
         if (TF.tf_addr == `MSWC_TF_CMD) begin
            s_next.irq = 1'b0;
         end
         case (TF.tf_addr)
            `MSWC_TF_ERR: s_next.rdata = {8'h00, err_out};
            `MSWC_TF_CNT: s_next.rdata = {8'h00, s_reg.cnt};
            `MSWC_TF_SNUM: s_next.rdata = {8'h00, s_reg.snum};
            `MSWC_TF_CLO: s_next.rdata = {8'h00, s_reg.clo};
            `MSWC_TF_CHI: s_next.rdata = {8'h00, s_reg.chi};
            `MSWC_TF_DH: s_next.rdata = {8'h00, s_reg.dh};
            `MSWC_TF_CMD: s_next.rdata = {8'h00, status};
            default: s_next.rdata = 16'h0000;
         endcase
      end
      case (s_reg.state)
         mswc_pkg::MSWC_D_IDLE: begin
            if (TF.tf_wr) begin
               case (TF.tf_addr)
                  `MSWC_TF_CNT: s_next.cnt = TF.tf_wdata[7:0];
                  `MSWC_TF_SNUM: s_next.snum = TF.tf_wdata[7:0];
                  `MSWC_TF_CLO: s_next.clo = TF.tf_wdata[7:0];
                  `MSWC_TF_CHI: s_next.chi = TF.tf_wdata[7:0];
                  `MSWC_TF_DH: s_next.dh = TF.tf_wdata[7:0];
                  `MSWC_TF_CMD: begin
                     s_next.err = 8'h00;
                     s_next.errflag = 1'b0;
                     s_next.first_done = 1'b0;
                     s_next.words = 8'h00;
                     s_next.rem = req_count;
                     s_next.is_log = (TF.tf_wdata[7:0] == `MSWC_OP_LOGDMA);
                     if ((TF.tf_wdata[7:0] == `MSWC_OP_WRMULT) &&
                         (BLOCK_SECTORS != 8'h00)) begin
                        s_next.blk = BLOCK_SECTORS;
                        s_next.state = mswc_pkg::MSWC_D_XFER;
                     end else if ((TF.tf_wdata[7:0] == `MSWC_OP_LOGDMA) && !log_bad) begin
                        // The whole log is one block, so it completes with one interrupt.
                        s_next.blk = s_reg.cnt;
                        s_next.state = mswc_pkg::MSWC_D_XFER;
                     end else begin
                        s_next.err[`MSWC_ER_ABT] = 1'b1;
                        s_next.errflag = 1'b1;
                        s_next.irq = 1'b1;
                     end
                  end
                  default: s_next.state = mswc_pkg::MSWC_D_IDLE;
               endcase
            end
         end
         mswc_pkg::MSWC_D_XFER: begin
            if (TF.tf_wr && (TF.tf_addr == `MSWC_TF_DATA)) begin
               s_next.mdata = TF.tf_wdata;
               s_next.mvalid = 1'b1;
               s_next.words = s_reg.words + 8'h01;
               if (s_reg.words == `MSWC_LAST_WORD) begin
                  s_next.state = mswc_pkg::MSWC_D_BUSY;
               end
            end
         end
         mswc_pkg::MSWC_D_BUSY: begin
            if (MEDIA_ERROR) begin
               // The failed sector stays counted as not transferred.
               s_next.cnt = s_reg.rem[7:0];
               s_next.err[s_reg.is_log ? `MSWC_ER_UNC : `MSWC_ER_IDN] = 1'b1;
               s_next.errflag = 1'b1;
               s_next.irq = 1'b1;
               s_next.state = mswc_pkg::MSWC_D_IDLE;
            end else begin
               s_next.sdone = 1'b1;
               s_next.rem = rem_dec;
               s_next.cnt = rem_dec[7:0];
               s_next.first_done = 1'b1;
               s_next.blk = s_reg.blk - 8'h01;
               if (s_reg.first_done) begin
                  {s_next.dh[3:0], s_next.chi, s_next.clo, s_next.snum} = next_addr;
               end
               if (s_reg.rem == 9'h001) begin
                  s_next.irq = 1'b1;
                  s_next.state = mswc_pkg::MSWC_D_IDLE;
               end else if (s_reg.blk == 8'h01) begin
                  s_next.irq = 1'b1;
                  s_next.blk = BLOCK_SECTORS;
                  s_next.state = mswc_pkg::MSWC_D_XFER;
               end else begin
                  s_next.state = mswc_pkg::MSWC_D_XFER;
               end
            end
         end
         default: s_next.state = mswc_pkg::MSWC_D_IDLE;
      endcase
   end

   // ==================================================================
   // State register
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         s_reg <= '0;
         s_reg.dh <= `MSWC_DH_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign TF.tf_rdata = s_reg.rdata;
   assign TF.intrq = s_reg.irq;
   assign MEDIA_WORD = s_reg.mdata;
   assign MEDIA_VALID = s_reg.mvalid;
   assign SECTOR_DONE = s_reg.sdone;
endmodule

// ---- core/mswc_host.sv ----
// Controller end: Avalon-MM register slave driving the taskfile link.
`include "mswc_defines.svh"
module mswc_host (
   input  wire logic        REF_CLK,
   input  wire logic        SYS_RST,
   input  wire logic [5:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   output logic      [31:0] AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   output logic             IRQ,
   mswc_if.host             TF
);
   mswc_pkg::mswc_host_type s_reg;
   mswc_pkg::mswc_host_type s_next;
   logic       eng_hit;
   logic       eng_free;
   logic       wr_take;
   logic [1:0] int_set;
   logic [1:0] int_clr;

   // ==================================================================
   // Bus handshake
   assign eng_hit = (AVS_ADDRESS == `MSWC_A_CMD) || (AVS_ADDRESS == `MSWC_A_DATA);
   // A pending device interrupt is served before any new engine order.
   assign eng_free = (s_reg.state == mswc_pkg::MSWC_H_IDLE) && !TF.intrq;
   assign AVS_WAITREQUEST = (AVS_READ && !s_reg.rd_ack) ||
                            (AVS_WRITE && eng_hit && !eng_free);
   assign wr_take = AVS_WRITE && !AVS_WAITREQUEST;

   always_comb begin
      s_next = s_reg;
      s_next.tf_wr = 1'b0;
      s_next.tf_rd = 1'b0;
      s_next.rd_ack = 1'b0;
      int_set = 2'b00;
      int_clr = 2'b00;
      if (AVS_READ && !s_reg.rd_ack) begin
         s_next.rd_ack = 1'b1;
         case (AVS_ADDRESS)
            `MSWC_A_CNT: s_next.rdata = {24'h000000, s_reg.cnt};
            `MSWC_A_SNUM: s_next.rdata = {24'h000000, s_reg.snum};
            `MSWC_A_CLO: s_next.rdata = {24'h000000, s_reg.clo};
            `MSWC_A_CHI: s_next.rdata = {24'h000000, s_reg.chi};
            `MSWC_A_DH: s_next.rdata = {24'h000000, s_reg.dh};
            `MSWC_A_CMD: s_next.rdata = {24'h000000, s_reg.cmd};
            `MSWC_A_RESA: s_next.rdata = s_reg.res_a;
            `MSWC_A_RESB: s_next.rdata = {8'h00, s_reg.res_b};
            `MSWC_A_IST: s_next.rdata = {30'h00000000, s_reg.ist};
            `MSWC_A_IMASK: s_next.rdata = {30'h00000000, s_reg.imask};
            `MSWC_A_ENG: s_next.rdata = {30'h00000000, TF.intrq,
                                         s_reg.state != mswc_pkg::MSWC_H_IDLE};
            default: s_next.rdata = 32'h00000000;
         endcase
      end
      if (wr_take) begin
         case (AVS_ADDRESS)
            `MSWC_A_CNT: s_next.cnt = AVS_WRITEDATA[7:0];
            `MSWC_A_SNUM: s_next.snum = AVS_WRITEDATA[7:0];
            `MSWC_A_CLO: s_next.clo = AVS_WRITEDATA[7:0];
            `MSWC_A_CHI: s_next.chi = AVS_WRITEDATA[7:0];
            `MSWC_A_DH: s_next.dh = AVS_WRITEDATA[7:0];
            `MSWC_A_CMD: begin
               s_next.cmd = AVS_WRITEDATA[7:0];
               s_next.step = 3'h0;
               s_next.state = mswc_pkg::MSWC_H_SEND;
            end
            `MSWC_A_DATA: begin
               s_next.tf_wr = 1'b1;
               s_next.tf_addr = `MSWC_TF_DATA;
               s_next.tf_wdata = AVS_WRITEDATA[15:0];
            end
            `MSWC_A_IST: int_clr = AVS_WRITEDATA[1:0];
            `MSWC_A_IMASK: s_next.imask = AVS_WRITEDATA[1:0];
            default: s_next.imask = s_reg.imask;
         endcase
      end
      // ==================================================================
      // Taskfile engine
      case (s_reg.state)
         mswc_pkg::MSWC_H_IDLE: begin
            if (TF.intrq) begin
               s_next.step = 3'h0;
               s_next.state = mswc_pkg::MSWC_H_FETCH;
            end
         end
         mswc_pkg::MSWC_H_SEND: begin
            s_next.tf_wr = 1'b1;
            s_next.tf_addr = s_reg.step + 3'h2;
            case (s_reg.step)
               3'h0: s_next.tf_wdata = {8'h00, s_reg.cnt};
               3'h1: s_next.tf_wdata = {8'h00, s_reg.snum};
               3'h2: s_next.tf_wdata = {8'h00, s_reg.clo};
               3'h3: s_next.tf_wdata = {8'h00, s_reg.chi};
               3'h4: s_next.tf_wdata = {8'h00, s_reg.dh};
               default: s_next.tf_wdata = {8'h00, s_reg.cmd};
            endcase
            s_next.step = s_reg.step + 3'h1;
            if (s_reg.step == 3'h5) begin
               s_next.state = mswc_pkg::MSWC_H_IDLE;
            end
         end
         mswc_pkg::MSWC_H_FETCH: begin
            // Status goes first so that the device drops its interrupt early.
            s_next.tf_rd = 1'b1;
            s_next.tf_addr = (s_reg.step == 3'h0) ? `MSWC_TF_CMD : s_reg.step;
            s_next.state = mswc_pkg::MSWC_H_WAIT;
         end
         mswc_pkg::MSWC_H_WAIT: s_next.state = mswc_pkg::MSWC_H_CATCH;
         mswc_pkg::MSWC_H_CATCH: begin
            case (s_reg.step)
               3'h0: s_next.res_b[7:0] = TF.tf_rdata[7:0];
               3'h1: s_next.res_b[15:8] = TF.tf_rdata[7:0];
               3'h2: s_next.res_a[7:0] = TF.tf_rdata[7:0];
               3'h3: s_next.res_a[15:8] = TF.tf_rdata[7:0];
               3'h4: s_next.res_a[23:16] = TF.tf_rdata[7:0];
               3'h5: s_next.res_a[31:24] = TF.tf_rdata[7:0];
               default: s_next.res_b[23:16] = TF.tf_rdata[7:0];
            endcase
            s_next.step = s_reg.step + 3'h1;
            s_next.state = mswc_pkg::MSWC_H_FETCH;
            if (s_reg.step == 3'h6) begin
               int_set[`MSWC_INT_DONE] = 1'b1;
               int_set[`MSWC_INT_ERR] = s_reg.res_b[`MSWC_ST_ERR];
               s_next.state = mswc_pkg::MSWC_H_IDLE;
            end
         end
         default: s_next.state = mswc_pkg::MSWC_H_IDLE;
      endcase
      // A new event wins over a clear in the same cycle.
      s_next.ist = (s_reg.ist & ~int_clr) | int_set;
   end

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         s_reg <= '0;
         s_reg.dh <= `MSWC_DH_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign AVS_READDATA = s_reg.rdata;
   assign IRQ = |(s_reg.ist & s_reg.imask);
   assign TF.tf_wr = s_reg.tf_wr;
   assign TF.tf_rd = s_reg.tf_rd;
   assign TF.tf_addr = s_reg.tf_addr;
   assign TF.tf_wdata = s_reg.tf_wdata;
endmodule

// ---- sim/mswc_checker.sv ----
// Concurrent checks on the taskfile link between the controller and the device.
`include "mswc_defines.svh"
module mswc_checker (
   input wire logic        REF_CLK,
   input wire logic        SYS_RST,
   input wire logic [2:0]  tf_addr,
   input wire logic        tf_wr,
   input wire logic        tf_rd,
   input wire logic [15:0] tf_wdata,
   input wire logic [15:0] tf_rdata,
   input wire logic        intrq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (SYS_RST);
   // ==================================================================
   // Link assertions
   AST_NO_RD_WR: assert property (!(tf_wr && tf_rd))
      else $error("Read and write strobes high together.");
   AST_CMD_BURST: assert property (tf_wr && tf_addr == `MSWC_TF_CNT |->
      ##1 (tf_wr && tf_addr == `MSWC_TF_SNUM) ##1 (tf_wr && tf_addr == `MSWC_TF_CLO)
      ##1 (tf_wr && tf_addr == `MSWC_TF_CHI) ##1 (tf_wr && tf_addr == `MSWC_TF_DH)
      ##1 (tf_wr && tf_addr == `MSWC_TF_CMD))
      else $error("Command block written out of order.");
   AST_INTRQ_CLEAR: assert property (tf_rd && tf_addr == `MSWC_TF_CMD |=> !intrq)
      else $error("Status read did not clear the interrupt.");
   AST_INTRQ_CAUSE: assert property ($rose(intrq) |->
      ($past(tf_wr) || $past(tf_wr, 2) || $past(tf_wr, 3)))
      else $error("Interrupt raised without a preceding write.");
   AST_RDATA_HOLD: assert property (!$past(tf_rd) |-> $stable(tf_rdata))
      else $error("Read answer changed without a read.");
   AST_STATUS_FIXED: assert property ($past(tf_rd) && $past(tf_addr) == `MSWC_TF_CMD |->
      tf_rdata[5] == 1'b0 && tf_rdata[2] == 1'b0 && !(tf_rdata[7] && tf_rdata[3]))
      else $error("Status answer has an illegal bit combination.");
   AST_ERR_BITS: assert property ($past(tf_rd) && $past(tf_addr) == `MSWC_TF_ERR |->
      (tf_rdata[7:0] & ~`MSWC_ERMASK_LOG) == 8'h00)
      else $error("Error answer sets a bit that must read zero.");
   AST_FETCH_ORDER: assert property (tf_rd && tf_addr == `MSWC_TF_CMD |->
      ##3 (tf_rd && tf_addr == `MSWC_TF_ERR) ##3 (tf_rd && tf_addr == `MSWC_TF_CNT))
      else $error("Result fetch out of order.");
   // ==================================================================
   // Scenario coverage
   COV_IRQ: cover property ($rose(intrq));
   COV_ERR: cover property ($past(tf_rd) && $past(tf_addr) == `MSWC_TF_CMD && tf_rdata[0]);
   COV_DATA: cover property (tf_wr && tf_addr == `MSWC_TF_DATA);
endmodule

// ---- sim/tb_multi_sector_write_command.sv ----
// Self-checking bench: controller and device joined, driven over Avalon-MM.
`include "mswc_defines.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
   $display("mismatch at %0t ns: got %h expected %h", $time, (got), (exp)); end end
module tb_multi_sector_write_command;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [5:0]  avs_address = 6'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        irq;
   logic [7:0]  block_sectors = 8'h01;
   logic [7:0]  log_sectors = 8'h04;
   logic        log_read_only = 1'b0;
   logic        log_supported = 1'b1;
   logic        media_error = 1'b0;
   logic [15:0] media_word;
   logic        media_valid;
   logic        sector_done;
   logic [31:0] q;
   int          n_errors = 0;
   int          tests_run = 0;
   int          n_done = 0;
   int          n_words = 0;
   logic [7:0]  rop [6] = '{8'h20, 8'hC5, 8'h57, 8'h57, 8'h57, 8'h57};
   logic [7:0]  rcnt [6] = '{8'h01, 8'h01, 8'h00, 8'h05, 8'h01, 8'h01};
   logic        rro [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
   logic        rsup [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
   mswc_if tf_link ();
   always #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (sector_done === 1'b1) n_done++;
   always @(posedge ref_clk) if (media_valid === 1'b1) n_words++;
   mswc_host i_mswc_host (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .AVS_ADDRESS(avs_address),
      .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
      .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .IRQ(irq), .TF(tf_link));
   mswc_device i_mswc_device (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .TF(tf_link),
      .BLOCK_SECTORS(block_sectors), .LOG_SECTORS(log_sectors), .LOG_READ_ONLY(log_read_only),
      .LOG_SUPPORTED(log_supported), .MEDIA_ERROR(media_error), .MEDIA_WORD(media_word),
      .MEDIA_VALID(media_valid), .SECTOR_DONE(sector_done));
   mswc_checker i_mswc_checker (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .tf_addr(tf_link.tf_addr),
      .tf_wr(tf_link.tf_wr), .tf_rd(tf_link.tf_rd), .tf_wdata(tf_link.tf_wdata),
      .tf_rdata(tf_link.tf_rdata), .intrq(tf_link.intrq));
   // ==================================================================
   // Bus tasks
   task automatic av(input logic [5:0] a, input logic w, input logic [31:0] d);
      @(posedge ref_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= d;
      // Only the watchdog ends a stalled transfer.
      do begin
         @(posedge ref_clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
      av(a, 1'b0, 32'h0);
      `CHK(q, exp)
   endtask
   task automatic issue(input logic [7:0] cnt, snum, clo, chi, dh, op);
      av(`MSWC_A_CNT, 1'b1, {24'h0, cnt});
      av(`MSWC_A_SNUM, 1'b1, {24'h0, snum});
      av(`MSWC_A_CLO, 1'b1, {24'h0, clo});
      av(`MSWC_A_CHI, 1'b1, {24'h0, chi});
      av(`MSWC_A_DH, 1'b1, {24'h0, dh});
      av(`MSWC_A_CMD, 1'b1, {24'h0, op});
   endtask
   // Software holds each data word until the controller frees the engine.
   task automatic sector(input logic [7:0] id);
      for (int i = 0; i < 256; i++) av(`MSWC_A_DATA, 1'b1, {16'h0, id, i[7:0]});
   endtask
   task automatic wait_ist(input logic [1:0] exp);
      int n;
      n = 0;
      q = 32'h0;
      while (q[1:0] == 2'b00 && n < 200) begin
         av(`MSWC_A_IST, 1'b0, 32'h0);
         n++;
      end
      `CHK(q[1:0], exp)
      av(`MSWC_A_IST, 1'b1, 32'h3);
   endtask
   task automatic finish_test;
      $display("Counts: %0d comparisons, %0d mismatches", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge ref_clk);
      n_errors++;
      finish_test();
   end
   // ==================================================================
   // Tests
   initial begin
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rd_chk(`MSWC_A_DH, 32'h0000_00A0);
      rd_chk(6'h30, 32'h0);
      rd_chk(`MSWC_A_IMASK, 32'h0);
      $display("Test reset done");
      av(`MSWC_A_IMASK, 1'b1, 32'h3);
      issue(8'h02, 8'hFF, 8'h34, 8'h12, 8'hE5, `MSWC_OP_WRMULT);
      sector(8'h01);
      av(`MSWC_A_IST, 1'b0, 32'h0);
      while (q[0] !== 1'b1 && tests_run < 10) av(`MSWC_A_IST, 1'b0, 32'h0);
      `CHK(irq, 1'b1)
      av(`MSWC_A_IMASK, 1'b1, 32'h0);
      @(posedge ref_clk);
      `CHK(irq, 1'b0)
      av(`MSWC_A_IMASK, 1'b1, 32'h3);
      av(`MSWC_A_IST, 1'b1, 32'h3);
      rd_chk(`MSWC_A_RESA, 32'h1234_FF01);
      sector(8'h02);
      repeat (3) @(posedge ref_clk);
      `CHK(media_word, 16'h02FF)
      wait_ist(2'b01);
      rd_chk(`MSWC_A_RESA, 32'h1235_0000);
      rd_chk(`MSWC_A_RESB, 32'h00E5_0050);
      $display("Test LBA write done");
      block_sectors <= 8'h02;
      issue(8'h03, 8'h3F, 8'hFF, 8'h00, 8'hAF, `MSWC_OP_WRMULT);
      sector(8'h11);
      repeat (40) @(posedge ref_clk);
      rd_chk(`MSWC_A_IST, 32'h0);
      sector(8'h12);
      wait_ist(2'b01);
      rd_chk(`MSWC_A_RESA, 32'h0100_0101);
      media_error <= 1'b1;
      sector(8'h13);
      wait_ist(2'b11);
      media_error <= 1'b0;
      av(`MSWC_A_RESB, 1'b0, 32'h0);
      `CHK(q[15:0], 16'h1051)
      av(`MSWC_A_RESA, 1'b0, 32'h0);
      `CHK(q[7:0], 8'h01)
      `CHK(n_done, 4)
      $display("Test CHS write done");
      block_sectors <= 8'h00;
      for (int k = 0; k < 6; k++) begin
         log_read_only <= rro[k];
         log_supported <= rsup[k];
         issue(rcnt[k], 8'h80, 8'h00, 8'h00, 8'hE0, rop[k]);
         wait_ist(2'b11);
         av(`MSWC_A_RESB, 1'b0, 32'h0);
         `CHK(q[15:0], 16'h0451)
      end
      log_read_only <= 1'b0;
      log_supported <= 1'b1;
      issue(8'h01, 8'h80, 8'h00, 8'h00, 8'hE0, `MSWC_OP_LOGDMA);
      sector(8'h21);
      wait_ist(2'b01);
      `CHK(media_word, 16'h21FF)
      av(`MSWC_A_RESB, 1'b0, 32'h0);
      `CHK(q[15:0], 16'h0050)
      $display("Test log write done");
      block_sectors <= 8'h01;
      issue(8'h00, 8'h80, 8'h00, 8'h00, 8'hE0, `MSWC_OP_WRMULT);
      sector(8'h31);
      wait_ist(2'b01);
      rd_chk(`MSWC_A_RESA, 32'h0000_80FF);
      rd_chk(`MSWC_A_RESB, 32'h00E0_0058);
      rd_chk(`MSWC_A_CMD, 32'h0000_00C5);
      // A reset in mid-transfer must leave both ends idle.
      sys_rst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rd_chk(`MSWC_A_ENG, 32'h0);
      rd_chk(`MSWC_A_RESA, 32'h0);
      rd_chk(`MSWC_A_DH, 32'h0000_00A0);
      `CHK(n_words, 1792)
      $display("Test zero count and reset done");
      finish_test();
   end
endmodule
